// ### design/ead_decode.sv
// effective-address decoder with cycle/access timing
// Functional notes
// - codes 00-07 select register direct operand
// - codes 0C-0F pointer indirect, post-update, no extension
// - codes 10-17 word register plus short offset
// - codes 18-1B pointer plus long offset
// - codes 1C-1D register 0/1 plus index
// - 1E program-counter relative; 1F direct; two bytes
// - extra mode cycles 2, 4 or 1
// - register accesses per mode 1, 2 or 0
// - internal register/even internal memory adds no cycles
// - odd internal memory: word +2, long +4
// - even 16-bit bus: +1, long +2
// - odd or 8-bit bus: +1, +4, +8
// - fetch corrections +2 internal, +3 external
// - external accesses also add ready wait cycles
// - register direct only 00-07; memory 08-1F
`timescale 1ns/1ns
`default_nettype none
module ead_decode (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              req_valid_i,
    input  wire ead_pkg::ead_req_t req_i,
    input  wire logic              want_reg_i,
    output logic                   res_valid_o,
    output ead_pkg::ead_res_t      res_o,
    output logic                   class_err_o
);
    ////////////////////////////////////////////////////////////////////////
    function automatic ead_pkg::ead_mode_t mode_of(input logic [4:0] c);
        if (c <= ead_pkg::EA_REG_LAST)       mode_of = ead_pkg::MODE_REG;
        else if (c < ead_pkg::EA_POST_FIRST) mode_of = ead_pkg::MODE_IND;
        else if (c < ead_pkg::EA_D8_FIRST)   mode_of = ead_pkg::MODE_POST;
        else if (c < ead_pkg::EA_D16_FIRST)  mode_of = ead_pkg::MODE_SHORT_OFFSET;
        else if (c < ead_pkg::EA_IDX0)       mode_of = ead_pkg::MODE_LONG_OFFSET;
        else if (c <= ead_pkg::EA_IDX1)      mode_of = ead_pkg::MODE_INDEX;
        else if (c == ead_pkg::EA_PCREL)     mode_of = ead_pkg::MODE_PCREL;
        else                                 mode_of = ead_pkg::MODE_DIRECT;
    endfunction : mode_of

    function automatic logic [2:0] size_bytes(input ead_pkg::ead_size_t s);
        case (s)
            ead_pkg::SZ_WORD: size_bytes = ead_pkg::ACC_TWO;
            ead_pkg::SZ_LONG: size_bytes = ead_pkg::ACC_FOUR;
            default:          size_bytes = ead_pkg::ACC_ONE;
        endcase
    endfunction : size_bytes

    ////////////////////////////////////////////////////////////////////////
    ead_pkg::ead_mode_t mode;
    ead_pkg::ead_res_t  res_next;
    logic [3:0]         opnd_cyc;
    logic [2:0]         opnd_acc;
    logic               err_next;

    assign mode = mode_of(req_i.code);

    ead_operand_cost u_cost (
        .size_i     (req_i.size),
        .mem_i      ((mode == ead_pkg::MODE_REG) ? ead_pkg::MEM_IREG : req_i.mem),
        .odd_i      (req_i.odd),
        .cycles_o   (opnd_cyc),
        .accesses_o (opnd_acc)
    );

    always_comb begin
        res_next               = '0;
        res_next.mode          = mode;
        res_next.base_reg      = req_i.code[2:0];
        res_next.opnd_cycles   = opnd_cyc;
        res_next.opnd_accesses = opnd_acc;
        res_next.ext_bus       = (mode != ead_pkg::MODE_REG)
                                 && (req_i.mem == ead_pkg::MEM_EXT16
                                     || req_i.mem == ead_pkg::MEM_EXT8);
        case (mode)
            ead_pkg::MODE_REG: begin
                // size picks byte, word or long register bank for same code
                res_next.base_reg = req_i.code[2:0];
            end
            ead_pkg::MODE_IND: begin
                res_next.base_reg     = {1'b0, req_i.code[1:0]};
                res_next.mode_cycles  = ead_pkg::CYC_MODE_FAST;
                res_next.reg_accesses = 2'h1;
            end
            ead_pkg::MODE_POST: begin
                res_next.base_reg     = {1'b0, req_i.code[1:0]};
                res_next.ext_bytes    = ead_pkg::EXT_NONE;
                res_next.mode_cycles  = ead_pkg::CYC_MODE_SLOW;
                res_next.reg_accesses = 2'h2;
                res_next.post_inc     = 1'b1;
                res_next.inc_bytes    = size_bytes(req_i.size);
            end
            ead_pkg::MODE_SHORT_OFFSET: begin
                res_next.ext_bytes    = ead_pkg::EXT_SHORT;
                res_next.mode_cycles  = ead_pkg::CYC_MODE_FAST;
                res_next.reg_accesses = 2'h1;
            end
            ead_pkg::MODE_LONG_OFFSET: begin
                res_next.base_reg     = {1'b0, req_i.code[1:0]};
                res_next.ext_bytes    = ead_pkg::EXT_LONG;
                res_next.mode_cycles  = ead_pkg::CYC_MODE_FAST;
                res_next.reg_accesses = 2'h1;
            end
            ead_pkg::MODE_INDEX: begin
                res_next.base_reg     = {2'b00, req_i.code[0]};
                res_next.use_index    = 1'b1;
                res_next.mode_cycles  = ead_pkg::CYC_MODE_SLOW;
                res_next.reg_accesses = 2'h2;
            end
            ead_pkg::MODE_PCREL: begin
                res_next.ext_bytes    = ead_pkg::EXT_LONG;
                res_next.mode_cycles  = ead_pkg::CYC_MODE_FAST;
            end
            default: begin
                res_next.ext_bytes    = ead_pkg::EXT_LONG;
                res_next.mode_cycles  = ead_pkg::CYC_MODE_DIR;
            end
        endcase
        // worst-case fetch penalty; real fetches often overlap execution
        case (req_i.mem)
            ead_pkg::MEM_INT:   res_next.fetch_cycles = req_i.fetch_odd ? ead_pkg::CYC_NONE
                                                        : ead_pkg::CYC_FETCH_INT;
            ead_pkg::MEM_EXT16: res_next.fetch_cycles = req_i.fetch_odd ? ead_pkg::CYC_NONE
                                                        : ead_pkg::CYC_FETCH_EXT;
            ead_pkg::MEM_EXT8:  res_next.fetch_cycles = ead_pkg::CYC_FETCH_EXT;
            default:            res_next.fetch_cycles = ead_pkg::CYC_NONE;
        endcase
    end

    // instruction class and code range must agree
    assign err_next = want_reg_i != (mode == ead_pkg::MODE_REG);

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            res_valid_o <= 1'b0;
        end else begin
            res_valid_o <= req_valid_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            res_o       <= '0;
            class_err_o <= 1'b0;
        end else if (req_valid_i) begin
            res_o       <= res_next;
            class_err_o <= err_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_req(logic [4:0] lo, logic [4:0] hi);
        req_valid_i && req_i.code >= lo && req_i.code <= hi;
    endsequence

    a_reg_direct: assert property (@(posedge clk_i) disable iff (rst_i)
        s_req(5'h00, 5'h07) |=> res_valid_o && res_o.mode == ead_pkg::MODE_REG
            && res_o.base_reg == $past(req_i.code[2:0]))
        else $error("register direct decode wrong");
    a_post_inc: assert property (@(posedge clk_i) disable iff (rst_i)
        s_req(5'h0c, 5'h0f) |=> res_o.post_inc && res_o.ext_bytes == 2'h0
            && res_o.base_reg == {1'b0, $past(req_i.code[1:0])})
        else $error("post-increment decode wrong");
    a_short_offset_ext: assert property (@(posedge clk_i) disable iff (rst_i)
        s_req(5'h10, 5'h17) |=> res_o.ext_bytes == 2'h1 && res_o.mode_cycles == 4'h2)
        else $error("short offset decode wrong");
    a_long_offset_ext: assert property (@(posedge clk_i) disable iff (rst_i)
        s_req(5'h18, 5'h1b) |=> res_o.ext_bytes == 2'h2 && res_o.reg_accesses == 2'h1)
        else $error("long offset decode wrong");
    a_index_mode: assert property (@(posedge clk_i) disable iff (rst_i)
        s_req(5'h1c, 5'h1d) |=> res_o.use_index && res_o.ext_bytes == 2'h0
            && res_o.mode_cycles == 4'h4 && res_o.reg_accesses == 2'h2)
        else $error("index decode wrong");
    a_direct_cost: assert property (@(posedge clk_i) disable iff (rst_i)
        s_req(5'h1f, 5'h1f) |=> res_o.mode_cycles == 4'h1 && res_o.ext_bytes == 2'h2
            && res_o.reg_accesses == 2'h0)
        else $error("direct address cost wrong");
    a_odd_long: assert property (@(posedge clk_i) disable iff (rst_i)
        req_valid_i && req_i.code >= 5'h08 && req_i.size == ead_pkg::SZ_LONG
            && req_i.mem == ead_pkg::MEM_EXT8
        |=> res_o.opnd_cycles == 4'h8 && res_o.opnd_accesses == 3'h4 && res_o.ext_bus)
        else $error("8-bit bus long cost wrong");
    a_inc_size: assert property (@(posedge clk_i) disable iff (rst_i)
        req_valid_i && req_i.code >= 5'h0c && req_i.code <= 5'h0f
            && req_i.size == ead_pkg::SZ_WORD |=> res_o.inc_bytes == 3'h2)
        else $error("increment size wrong");
    a_class_err: assert property (@(posedge clk_i) disable iff (rst_i)
        req_valid_i && want_reg_i && req_i.code >= 5'h08 |=> class_err_o)
        else $error("class mismatch not flagged");
    a_class_ok: assert property (@(posedge clk_i) disable iff (rst_i)
        req_valid_i && !want_reg_i && req_i.code >= 5'h08 |=> !class_err_o)
        else $error("memory operand wrongly flagged");
    a_ind_cost: assert property (@(posedge clk_i) disable iff (rst_i)
        s_req(5'h08, 5'h0b) |=> res_o.mode_cycles == 4'h2 && res_o.reg_accesses == 2'h1
            && res_o.ext_bytes == 2'h0 && !res_o.post_inc)
        else $error("plain indirect cost wrong");
    a_pcrel_mode: assert property (@(posedge clk_i) disable iff (rst_i)
        s_req(5'h1e, 5'h1e) |=> res_o.mode == ead_pkg::MODE_PCREL && res_o.ext_bytes == 2'h2
            && res_o.mode_cycles == 4'h2 && res_o.reg_accesses == 2'h0)
        else $error("program-counter relative decode wrong");
    a_long_offset_base: assert property (@(posedge clk_i) disable iff (rst_i)
        s_req(5'h18, 5'h1b) |=> res_o.base_reg == {1'b0, $past(req_i.code[1:0])})
        else $error("long offset pointer wrong");
    a_index_base: assert property (@(posedge clk_i) disable iff (rst_i)
        s_req(5'h1c, 5'h1d) |=> res_o.base_reg == {2'b00, $past(req_i.code[0])})
        else $error("index base register wrong");

    // memory operand of a given location, width and alignment
    sequence s_mem(ead_pkg::ead_mem_t m, ead_pkg::ead_size_t s, logic o);
        req_valid_i && req_i.code >= 5'h08 && req_i.mem == m && req_i.size == s
            && req_i.odd == o;
    endsequence

    a_reg_opnd: assert property (@(posedge clk_i) disable iff (rst_i)
        req_valid_i && req_i.code <= 5'h07 && req_i.size == ead_pkg::SZ_LONG
        |=> res_o.opnd_cycles == 4'h0 && res_o.opnd_accesses == 3'h2 && !res_o.ext_bus)
        else $error("register operand cost wrong");
    a_odd_word: assert property (@(posedge clk_i) disable iff (rst_i)
        s_mem(ead_pkg::MEM_INT, ead_pkg::SZ_WORD, 1'b1)
        |=> res_o.opnd_cycles == 4'h2 && res_o.opnd_accesses == 3'h2 && !res_o.ext_bus)
        else $error("odd internal word cost wrong");
    a_even_long: assert property (@(posedge clk_i) disable iff (rst_i)
        s_mem(ead_pkg::MEM_EXT16, ead_pkg::SZ_LONG, 1'b0)
        |=> res_o.opnd_cycles == 4'h2 && res_o.opnd_accesses == 3'h2 && res_o.ext_bus)
        else $error("even 16-bit bus long cost wrong");
    a_fetch_narrow: assert property (@(posedge clk_i) disable iff (rst_i)
        req_valid_i && req_i.mem == ead_pkg::MEM_EXT8 |=> res_o.fetch_cycles == 4'h3)
        else $error("8-bit bus fetch cost wrong");
endmodule : ead_decode
`default_nettype wire

// ### design/ead_operand_cost.sv
// operand-width/location cycle and access corrections
`timescale 1ns/1ns
`default_nettype none
module ead_operand_cost (
    input  wire ead_pkg::ead_size_t size_i,
    input  wire ead_pkg::ead_mem_t  mem_i,
    input  wire logic               odd_i,
    output logic [3:0]              cycles_o,
    output logic [2:0]              accesses_o
);
    always_comb begin
        cycles_o   = ead_pkg::CYC_NONE;
        accesses_o = ead_pkg::ACC_ONE;
        case (mem_i)
            ead_pkg::MEM_IREG: begin
                if (size_i == ead_pkg::SZ_LONG) accesses_o = ead_pkg::ACC_TWO;
            end
            ead_pkg::MEM_INT: begin
                if (!odd_i) begin
                    if (size_i == ead_pkg::SZ_LONG) accesses_o = ead_pkg::ACC_TWO;
                end else if (size_i == ead_pkg::SZ_WORD) begin
                    cycles_o   = ead_pkg::CYC_ODD_WORD;
                    accesses_o = ead_pkg::ACC_TWO;
                end else if (size_i == ead_pkg::SZ_LONG) begin
                    cycles_o   = ead_pkg::CYC_ODD_LONG;
                    accesses_o = ead_pkg::ACC_FOUR;
                end
            end
            default: begin
                // 8-bit bus behaves like an odd 16-bit access at every size
                if (mem_i == ead_pkg::MEM_EXT16 && !odd_i) begin
                    cycles_o = (size_i == ead_pkg::SZ_LONG) ? ead_pkg::CYC_EXT_LONG2
                                                            : ead_pkg::CYC_EXT_SHORT;
                    if (size_i == ead_pkg::SZ_LONG) accesses_o = ead_pkg::ACC_TWO;
                end else begin
                    case (size_i)
                        ead_pkg::SZ_WORD: begin
                            cycles_o   = ead_pkg::CYC_EXT_WORD4;
                            accesses_o = ead_pkg::ACC_TWO;
                        end
                        ead_pkg::SZ_LONG: begin
                            cycles_o   = ead_pkg::CYC_EXT_LONG8;
                            accesses_o = ead_pkg::ACC_FOUR;
                        end
                        default: cycles_o = ead_pkg::CYC_EXT_SHORT;
                    endcase
                end
            end
        endcase
    end
endmodule : ead_operand_cost
`default_nettype wire

// ### design/ead_pkg.sv
// package: effective-address decode constants and carriers
package ead_pkg;
    localparam int EA_W = 5;
    localparam logic [4:0] EA_REG_LAST    = 5'h07;
    localparam logic [4:0] EA_IND_FIRST   = 5'h08;
    localparam logic [4:0] EA_POST_FIRST  = 5'h0c;
    localparam logic [4:0] EA_D8_FIRST    = 5'h10;
    localparam logic [4:0] EA_D16_FIRST   = 5'h18;
    localparam logic [4:0] EA_IDX0        = 5'h1c;
    localparam logic [4:0] EA_IDX1        = 5'h1d;
    localparam logic [4:0] EA_PCREL       = 5'h1e;
    localparam logic [4:0] EA_DIRECT      = 5'h1f;
    localparam logic [2:0] INDEX_REG_NUM  = 3'h7;
    localparam logic [1:0] EXT_NONE       = 2'h0;
    localparam logic [1:0] EXT_SHORT      = 2'h1;
    localparam logic [1:0] EXT_LONG       = 2'h2;
    localparam logic [3:0] CYC_MODE_FAST  = 4'h2;
    localparam logic [3:0] CYC_MODE_SLOW  = 4'h4;
    localparam logic [3:0] CYC_MODE_DIR   = 4'h1;
    localparam logic [3:0] CYC_NONE       = 4'h0;
    localparam logic [3:0] CYC_ODD_WORD   = 4'h2;
    localparam logic [3:0] CYC_ODD_LONG   = 4'h4;
    localparam logic [3:0] CYC_EXT_SHORT  = 4'h1;
    localparam logic [3:0] CYC_EXT_LONG2  = 4'h2;
    localparam logic [3:0] CYC_EXT_WORD4  = 4'h4;
    localparam logic [3:0] CYC_EXT_LONG8  = 4'h8;
    localparam logic [3:0] CYC_FETCH_INT  = 4'h2;
    localparam logic [3:0] CYC_FETCH_EXT  = 4'h3;
    localparam logic [2:0] ACC_ONE        = 3'h1;
    localparam logic [2:0] ACC_TWO        = 3'h2;
    localparam logic [2:0] ACC_FOUR       = 3'h4;

    typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG, SZ_RSVD} ead_size_t;
    typedef enum logic [1:0] {MEM_IREG, MEM_INT, MEM_EXT16, MEM_EXT8} ead_mem_t;
    typedef enum logic [2:0] {
        MODE_REG, MODE_IND, MODE_POST, MODE_SHORT_OFFSET,
        MODE_LONG_OFFSET, MODE_INDEX, MODE_PCREL, MODE_DIRECT
    } ead_mode_t;

    typedef struct packed {
        logic [4:0] code;
        ead_size_t  size;
        ead_mem_t   mem;
        logic       odd;
        logic       fetch_odd;
    } ead_req_t;

    typedef struct packed {
        ead_mode_t  mode;
        logic [2:0] base_reg;
        logic       use_index;
        logic [1:0] ext_bytes;
        logic [3:0] mode_cycles;
        logic [1:0] reg_accesses;
        logic [3:0] opnd_cycles;
        logic [2:0] opnd_accesses;
        logic [3:0] fetch_cycles;
        logic       post_inc;
        logic [2:0] inc_bytes;
        logic       ext_bus;
    } ead_res_t;
endpackage : ead_pkg

// ### verification/ead_seq_model.sv
// sequencer-side model: presents decode requests and sums an instruction's cycles
`timescale 1ns/1ns
`default_nettype none
module ead_seq_model #(
    parameter int WAITS = 3
) (
    input  wire logic              go_i,
    input  wire ead_pkg::ead_req_t cmd_i,
    input  wire logic              want_i,
    output logic                   req_valid_o,
    output ead_pkg::ead_req_t      req_o,
    output logic                   want_reg_o,
    input  wire ead_pkg::ead_res_t res_i,
    output logic [5:0]             total_o
);
    // released request lines show the inverse, so stale fields cannot pass by luck
    assign req_valid_o = go_i;
    assign req_o       = go_i ? cmd_i : ead_pkg::ead_req_t'(~cmd_i);
    assign want_reg_o  = go_i ? want_i : ~want_i;
    // wait states only when the decoder flags an external access
    assign total_o = 6'(res_i.mode_cycles) + 6'(res_i.opnd_cycles) + 6'(res_i.fetch_cycles)
                   + (res_i.ext_bus ? 6'(WAITS) : 6'h00);
endmodule : ead_seq_model
`default_nettype wire

// ### verification/tb_effective_address_decode_timing.sv
// self-checking bench for the effective-address decoder
`timescale 1ns/1ns
`default_nettype none
module tb_effective_address_decode_timing;
    localparam int WAITS = 3;
    logic              clk_i, rst_i, go, want, req_valid, want_reg, res_valid, class_err;
    logic [5:0]        total;
    ead_pkg::ead_req_t cmd, req;
    ead_pkg::ead_res_t res;
    int                fail_count = 0, n_tests = 0, cycles = 0;
    int                ext_t[8] = '{0, 0, 0, 1, 2, 0, 2, 2};
    int                mcyc_t[8] = '{0, 2, 4, 2, 2, 4, 2, 1};
    int                racc_t[8] = '{0, 1, 2, 1, 1, 2, 0, 0};

    ead_decode u_ead_decode (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid),
        .req_i(req), .want_reg_i(want_reg), .res_valid_o(res_valid), .res_o(res),
        .class_err_o(class_err));
    ead_seq_model #(.WAITS(WAITS)) u_ead_seq_model (.go_i(go), .cmd_i(cmd), .want_i(want),
        .req_valid_o(req_valid), .req_o(req), .want_reg_o(want_reg), .res_i(res),
        .total_o(total));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    task automatic close_out();
        $display("checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    // entered 1 ns after an edge; go stays up so successive calls run back to back
    task automatic send(input logic [4:0] c, input int sz, input int mm, input logic odd,
                        input logic fodd, input logic w);
        go = 1'b1;
        want = w;
        cmd = '{c, ead_pkg::ead_size_t'(sz), ead_pkg::ead_mem_t'(mm), odd, fodd};
        @(posedge clk_i);
        #1;
        check("res_valid", 16'(res_valid), 16'h0001);
    endtask : send

    function automatic int mode_of(input logic [4:0] c);
        if (c <= 5'h07) return 0;
        if (c <= 5'h0b) return 1;
        if (c <= 5'h0f) return 2;
        if (c <= 5'h17) return 3;
        if (c <= 5'h1b) return 4;
        if (c <= 5'h1d) return 5;
        return (c == 5'h1e) ? 6 : 7;
    endfunction : mode_of

    ////////////////////////////////////////////////////////////////////////////////
    task automatic scen_codes();
        int m;
        for (int c = 0; c < 32; c++) begin
            send(5'(c), 1, 1, 1'b0, 1'b0, c < 8);
            m = mode_of(5'(c));
            check("mode", 16'(res.mode), 16'(m));
            check("ext_bytes", 16'(res.ext_bytes), 16'(ext_t[m]));
            check("mode_cycles", 16'(res.mode_cycles), 16'(mcyc_t[m]));
            check("reg_accesses", 16'(res.reg_accesses), 16'(racc_t[m]));
            check("post_inc", 16'(res.post_inc), 16'(m == 2));
            check("class_err", 16'(class_err), 16'h0000);
            if (m == 0) check("base_reg", 16'(res.base_reg), 16'(c));
            if (m == 1 || m == 2) check("base_reg", 16'(res.base_reg), 16'(c % 4));
            if (m == 5) check("base_reg", 16'(res.base_reg), 16'(c % 2));
            if (m == 3) check("base_reg", 16'(res.base_reg), 16'(c % 8));
            if (m == 4) check("base_reg", 16'(res.base_reg), 16'(c % 4));
            if (m == 5) check("use_index", 16'(res.use_index), 16'h0001);
        end
    endtask : scen_codes

    task automatic scen_cost();
        int ec, ea, fc;
        for (int s = 0; s < 3; s++) for (int mm = 0; mm < 4; mm++) for (int o = 0; o < 2; o++) begin
            send(5'h08, s, mm, o[0], 1'b0, 1'b0);
            ea = (s == 2) ? 2 : 1;
            ec = (mm >= 2) ? ((s == 2) ? 2 : 1) : 0;
            if (mm == 1 && o == 1) begin
                ec = 2 * s;
                ea = (s == 0) ? 1 : 2 * s;
            end
            if (mm == 3 || (mm == 2 && o == 1)) begin
                ec = (s == 0) ? 1 : 4 * s;
                ea = (s == 0) ? 1 : 2 * s;
            end
            fc = (mm == 0) ? 0 : (mm == 1) ? 2 : 3;
            check("opnd_cycles", 16'(res.opnd_cycles), 16'(ec));
            check("opnd_acc", 16'(res.opnd_accesses), 16'(ea));
            check("ext_bus", 16'(res.ext_bus), 16'(mm >= 2));
            check("total", 16'(total), 16'(2 + ec + fc + ((mm >= 2) ? WAITS : 0)));
        end
        send(5'h03, 2, 3, 1'b1, 1'b0, 1'b1);
        check("reg_opnd_cycles", 16'(res.opnd_cycles), 16'h0000);
        check("reg_opnd_acc", 16'(res.opnd_accesses), 16'h0002);
    endtask : scen_cost

    task automatic scen_fetch();
        for (int mm = 0; mm < 4; mm++) for (int f = 0; f < 2; f++) begin
            send(5'h1f, 0, mm, 1'b0, f[0], 1'b0);
            check("fetch", 16'(res.fetch_cycles),
                  16'((mm == 3 || (mm == 2 && f == 0)) ? 3 : (mm == 1 && f == 0) ? 2 : 0));
        end
    endtask : scen_fetch

    task automatic scen_class_inc();
        send(5'h08, 0, 1, 1'b0, 1'b0, 1'b1);
        check("class_mem", 16'(class_err), 16'h0001);
        send(5'h07, 0, 0, 1'b0, 1'b0, 1'b0);
        check("class_reg", 16'(class_err), 16'h0001);
        for (int s = 0; s < 3; s++) begin
            send(5'h0d, s, 1, 1'b0, 1'b0, 1'b0);
            check("inc_bytes", 16'(res.inc_bytes), 16'(1 << s));
        end
    endtask : scen_class_inc

    task automatic scen_idle_reset();
        go = 1'b0;
        @(posedge clk_i);
        #1;
        check("idle_valid", 16'(res_valid), 16'h0000);
        check("hold_inc", 16'(res.inc_bytes), 16'h0004);
        rst_i = 1'b1;
        #1;
        check("rst_res", 16'(res.mode_cycles), 16'h0000);
        check("rst_inc", 16'(res.inc_bytes), 16'h0000);
        @(posedge clk_i);
        #1;
        rst_i = 1'b0;
    endtask : scen_idle_reset

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            close_out();
        end
    end

    initial begin
        rst_i = 1'b1;
        go = 1'b0;
        want = 1'b0;
        cmd = '0;
        repeat (4) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        scen_codes();
        scen_cost();
        scen_fetch();
        scen_class_inc();
        scen_idle_reset();
        scen_codes();
        close_out();
    end
endmodule : tb_effective_address_decode_timing
`default_nettype wire
